// ### rtl/oflash_map_strobe.sv
module oflash_map_strobe (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // Avalon-MM slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Read data phase from the link
  input  wire logic        RD_PHASE,
  input  wire logic        LINK_RDY,
  // Data and strobe pins
  output logic [7:0]       DQ_OUT,
  output logic             DQ_OE_N,
  output logic             DS_OUT,
  output logic             DS_OE_N
);
  // ==========================================
  // Register state
  logic [4:0]  ctrl_r;        // Mode, protocol, density
  logic [7:0]  cfg1_r;        // nv_config_reg_one image
  logic [7:0]  cfg3_r;        // nv_config_reg_three image
  logic [31:0] addr_r;        // Last address written
  logic        crc_ok_r;      // Sticky: CRC read accepted
  logic        crc_ref_r;     // Sticky: CRC read refused
  logic        lsb_err_r;     // Odd address seen in DDR
  logic        ack_r;         // Bus answer cycle
  logic [31:0] rdata_r;       // Read data holding
  // ==========================================
  // Bus decode
  logic        req;           // Any request pending
  logic        hit_data;      // Data register write
  logic        stall;         // Buffer full on data write
  logic        wr_en;         // Write takes effect now
  logic        wr_ctrl;       // Control write
  logic        wr_cmd;        // Command write
  logic        wr_addr;       // Address write
  logic        wr_stat;       // Status write, clears CRC flags
  logic        cmd_enter;     // Enter four-byte command
  logic        cmd_exit;      // Exit four-byte command
  logic        cmd_crc;       // CRC read command
  logic        ddr_mode;      // Octal DDR active
  logic [31:0] rd_mux;        // Selected read value
  logic        buf_in_rdy;    // Room for a word
  logic        buf_out_vld;   // Word waiting for the pins
  logic [7:0]  buf_out_data;  // Head word
  logic        pop;           // Word taken by the pin stage

  assign req       = AVS_READ | AVS_WRITE;
  assign hit_data  = AVS_WRITE & (AVS_ADDRESS == oflash_pkg::OFS_DATA);
  assign stall     = hit_data & ~buf_in_rdy;
  assign AVS_WAITREQUEST = req & ~ack_r;
  assign wr_en     = AVS_WRITE & ack_r;
  assign wr_ctrl   = wr_en & (AVS_ADDRESS == oflash_pkg::OFS_CTRL);
  assign wr_cmd    = wr_en & (AVS_ADDRESS == oflash_pkg::OFS_CMD);
  assign wr_addr   = wr_en & (AVS_ADDRESS == oflash_pkg::OFS_ADDR);
  assign wr_stat   = wr_en & (AVS_ADDRESS == oflash_pkg::OFS_STAT);
  assign cmd_enter = wr_cmd & (AVS_WRITEDATA[7:0] == oflash_pkg::CMD_ENTER4);
  assign cmd_exit  = wr_cmd & (AVS_WRITEDATA[7:0] == oflash_pkg::CMD_EXIT4);
  assign cmd_crc   = wr_cmd & (AVS_WRITEDATA[7:0] == oflash_pkg::CMD_CRCRD);
  assign ddr_mode  = (ctrl_r[oflash_pkg::CTRL_PROTO +: 2]
                      == oflash_pkg::PROTO_8D);
  // ==========================================
  // Address handling
  logic        four_byte;     // Four-byte address mode
  logic [1:0]  dens;          // 0: 256Mb, 1: 512Mb, 2: 1Gb
  logic [31:0] eff_addr;      // Address after mode masking
  logic        out_range;     // Beyond the part's array
  assign four_byte = ctrl_r[oflash_pkg::CTRL_FOUR];
  assign dens      = ctrl_r[oflash_pkg::CTRL_DENS +: 2];
  // three-byte masking
  // Top byte is dropped in three-byte mode, so it never reaches decode
  assign eff_addr  = four_byte ? addr_r : {8'h00, addr_r[23:0]};
  // full reach, array size by density
  assign out_range = (eff_addr >> (6'd25 + {4'h0, dens})) != 32'h0;
  // ==========================================
  // Sector layout select
  oflash_pkg::layout_t layout;
  logic        uni_sel;       // Uniform requested
  logic        split_sel;     // Split hybrid requested
  logic        top_sel;       // Top group requested
  assign uni_sel   = cfg3_r[oflash_pkg::CFG3_UNI];
  assign split_sel = cfg1_r[oflash_pkg::CFG1_SPLIT];
  assign top_sel   = cfg1_r[oflash_pkg::CFG1_TOP];
  assign layout = uni_sel   ? oflash_pkg::LAY_UNIFORM :
                  split_sel ? oflash_pkg::LAY_SPLIT   :
                  top_sel   ? oflash_pkg::LAY_TOP     :
                              oflash_pkg::LAY_BOTTOM;
  // ==========================================
  // Sector decode: {size code, index}
  function automatic logic [11:0] sect_of(input logic [31:0] a,
                                          input oflash_pkg::layout_t l,
                                          input logic [1:0] d);
    logic [9:0]  blk;
    logic [9:0]  last;
    logic [17:0] o;
    logic [9:0]  idx;
    logic [1:0]  sz;
    blk  = {1'b0, a[26:18]};
    last = (oflash_pkg::NSEC_MIN << d) - 10'h001;
    o    = a[17:0];
    idx  = blk;
    sz   = oflash_pkg::SZ_256K;
    unique case (l)
      // bottom group of 4K then 128K
      oflash_pkg::LAY_BOTTOM:
      begin
        if (blk != 10'h000)
          idx = blk + oflash_pkg::NSMALL1;
        else if (o < oflash_pkg::OFS_128K)
        begin
          idx = {4'h0, o[17:12]};
          sz  = oflash_pkg::SZ_4K;
        end
        else
        begin
          idx = oflash_pkg::NSMALL1;
          sz  = oflash_pkg::SZ_128K;
        end
      end
      oflash_pkg::LAY_TOP:
      begin
        if (blk == last && o < oflash_pkg::OFS_128K)
          sz = oflash_pkg::SZ_128K;
        else if (blk == last)
        begin
          idx = last + 10'h001 + {5'h00, o[16:12]};
          sz  = oflash_pkg::SZ_4K;
        end
      end
      // sixteen 4K plus 192K at both ends
      oflash_pkg::LAY_SPLIT:
      begin
        if (blk == 10'h000 && o < oflash_pkg::OFS_64K)
        begin
          idx = {6'h00, o[15:12]};
          sz  = oflash_pkg::SZ_4K;
        end
        else if (blk == 10'h000)
        begin
          idx = oflash_pkg::NSMALL2;
          sz  = oflash_pkg::SZ_192K;
        end
        else if (blk == last && o >= oflash_pkg::OFS_192K)
        begin
          idx = blk + oflash_pkg::NSMALL2 + 10'h001 + {6'h00, o[15:12]};
          sz  = oflash_pkg::SZ_4K;
        end
        else
        begin
          idx = blk + oflash_pkg::NSMALL2;
          sz  = (blk == last) ? oflash_pkg::SZ_192K : oflash_pkg::SZ_256K;
        end
      end
      oflash_pkg::LAY_UNIFORM:
        idx = blk;
    endcase
    return {sz, idx};
  endfunction

  logic [11:0] sect;          // Decoded sector word
  assign sect = sect_of(eff_addr, layout, dens);
  // ==========================================
  // Read mux, unmapped reads return zero
  assign rd_mux =
    (AVS_ADDRESS == oflash_pkg::OFS_CTRL) ? {27'h0, ctrl_r} :
    (AVS_ADDRESS == oflash_pkg::OFS_CFG1) ? {24'h0, cfg1_r} :
    (AVS_ADDRESS == oflash_pkg::OFS_CFG3) ? {24'h0, cfg3_r} :
    (AVS_ADDRESS == oflash_pkg::OFS_ADDR) ? addr_r :
    (AVS_ADDRESS == oflash_pkg::OFS_SECT) ?
      {14'h0, layout, 4'h0, sect} :
    (AVS_ADDRESS == oflash_pkg::OFS_STAT) ?
      {26'h0, buf_out_vld, out_range, lsb_err_r,
       crc_ref_r, crc_ok_r, four_byte} :
    32'h0;
  assign AVS_READDATA = rdata_r;
  // Answer one cycle after the request; data writes wait for room
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0;
    end
    else
    begin
      ack_r   <= req & ~ack_r & ~stall;
      rdata_r <= rd_mux;
    end
  end

  // Configuration and address registers
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_r <= oflash_pkg::CTRL_RST;
      cfg1_r <= oflash_pkg::CFG1_RST;
      cfg3_r <= oflash_pkg::CFG3_RST;
      addr_r <= 32'h0;
    end
    else
    begin
      // mode by register bit or command
      if (wr_ctrl)
        ctrl_r <= AVS_WRITEDATA[4:0];
      else if (cmd_enter)
        ctrl_r[oflash_pkg::CTRL_FOUR] <= 1'b1;
      else if (cmd_exit)
        ctrl_r[oflash_pkg::CTRL_FOUR] <= 1'b0;
      if (wr_en && AVS_ADDRESS == oflash_pkg::OFS_CFG1)
        cfg1_r <= AVS_WRITEDATA[7:0];
      if (wr_en && AVS_ADDRESS == oflash_pkg::OFS_CFG3)
        cfg3_r <= AVS_WRITEDATA[7:0];
      if (wr_addr)
        addr_r <= AVS_WRITEDATA;
    end
  end

  // Sticky CRC flags: a set in the clearing cycle wins; lsb_err_r follows each address write
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      crc_ok_r  <= 1'b0;
      crc_ref_r <= 1'b0;
      lsb_err_r <= 1'b0;
    end
    else
    begin
      crc_ok_r  <= (cmd_crc & ddr_mode) |
                   (crc_ok_r & ~(wr_stat &
                                 AVS_WRITEDATA[oflash_pkg::ST_CRC_OK]));
      crc_ref_r <= (cmd_crc & ~ddr_mode) |
                   (crc_ref_r & ~(wr_stat &
                                  AVS_WRITEDATA[oflash_pkg::ST_CRC_REF]));
      if (wr_addr)
        lsb_err_r <= ddr_mode & AVS_WRITEDATA[0];
    end
  end
  // ==========================================
  // Read data buffer between bus and pins
  // Push only on the answer edge, so a held write is taken once
  word_buf2 #(.WIDTH(8)) u_buf (
    .clk       (CLK_SYS),
    .nrst      (NRST),
    .in_valid  (hit_data & ack_r),
    .in_ready  (buf_in_rdy),
    .in_data   (AVS_WRITEDATA[7:0]),
    .out_valid (buf_out_vld),
    .out_ready (pop),
    .out_data  (buf_out_data)
  );
  // ==========================================
  // Pin stage: data and strobe
  oflash_pkg::phase_t ph_r;   // SDR bit half
  logic [7:0] dq_r;           // Data on the pins
  logic       ds_r;           // Strobe level
  logic       oe_n_r;         // Shared output enable
  // Pop only at a bit start; SDR holds each bit two cycles
  assign pop = RD_PHASE & LINK_RDY & buf_out_vld &
               (ddr_mode | ph_r == oflash_pkg::PH_LOAD);
  assign DQ_OUT  = dq_r;
  assign DS_OUT  = ds_r;
  assign DQ_OE_N = oe_n_r;
  assign DS_OE_N = oe_n_r;

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      oe_n_r <= 1'b1;
    else
      oe_n_r <= ~RD_PHASE;
  end

  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      ph_r <= oflash_pkg::PH_LOAD;
      dq_r <= 8'h00;
      ds_r <= 1'b0;
    end
    else if (!RD_PHASE)
    begin
      ph_r <= oflash_pkg::PH_LOAD;
      ds_r <= 1'b0;
    end
    else if (ddr_mode)
    begin
      // Edge aligned: strobe flips with the data
      if (pop)
      begin
        dq_r <= buf_out_data;
        ds_r <= ~ds_r;
      end
    end
    else
    begin
      unique case (ph_r)
        // Data changes with strobe low
        oflash_pkg::PH_LOAD:
          if (pop)
          begin
            dq_r <= buf_out_data;
            ds_r <= 1'b0;
            ph_r <= oflash_pkg::PH_MID;
          end
        // Strobe rises at mid bit
        oflash_pkg::PH_MID:
        begin
          ds_r <= 1'b1;
          ph_r <= oflash_pkg::PH_LOAD;
        end
      endcase
    end
  end
  // ==========================================
  // Checks
  a_ds_enable: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    RD_PHASE |=> !DS_OE_N) else $error("strobe not driven");
  a_ds_ddr_edge: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (pop && ddr_mode) |=> (DS_OUT != $past(DS_OUT)) &&
    (DQ_OUT == $past(buf_out_data))) else $error("ddr strobe");
  a_ds_sdr_mid: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (pop && !ddr_mode) |=> !DS_OUT ##1 (DS_OUT || !$past(RD_PHASE)))
    else $error("sdr strobe not centred");
  a_crc_gate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cmd_crc && !ddr_mode) |=> crc_ref_r && !$rose(crc_ok_r))
    else $error("crc read not refused");
  a_mode_enter: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (cmd_enter && !wr_ctrl) |=> four_byte) else $error("enter");
  a_mode_mask: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !four_byte |-> eff_addr[31:24] == 8'h00) else $error("mask");
  a_uni_index: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (layout == oflash_pkg::LAY_UNIFORM) |->
    sect[9:0] == {1'b0, eff_addr[26:18]} &&
    sect[11:10] == oflash_pkg::SZ_256K) else $error("index");
  a_lsb_flag: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (wr_addr && ddr_mode && AVS_WRITEDATA[0]) |=> lsb_err_r)
    else $error("odd address not flagged");
  a_sect_count: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (layout == oflash_pkg::LAY_UNIFORM && !out_range) |->
    {1'b0, sect[9:0]} < ({1'b0, oflash_pkg::NSEC_MIN} << dens))
    else $error("sector count");
  a_uni_select: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    uni_sel |-> layout == oflash_pkg::LAY_UNIFORM)
    else $error("layout select");

  c_ddr_burst: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    (pop && ddr_mode) ##1 (pop && ddr_mode));
  c_sdr_word: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    pop && !ddr_mode);
  c_buf_stall: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    stall ##1 !stall);
  c_top_small: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    layout == oflash_pkg::LAY_TOP && sect[11:10] == oflash_pkg::SZ_4K);
endmodule

// ### rtl/oflash_pkg.sv
package oflash_pkg;
  // ==========================================
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CFG1 = 5'h04;
  localparam logic [4:0] OFS_CFG3 = 5'h08;
  localparam logic [4:0] OFS_CMD  = 5'h0c;
  localparam logic [4:0] OFS_ADDR = 5'h10;
  localparam logic [4:0] OFS_SECT = 5'h14;
  localparam logic [4:0] OFS_DATA = 5'h18;
  localparam logic [4:0] OFS_STAT = 5'h1c;
  // ==========================================
  // Field positions
  localparam int CTRL_FOUR  = 0;
  localparam int CTRL_PROTO = 1;
  localparam int CTRL_DENS  = 3;
  localparam int CFG1_TOP   = 2;
  localparam int CFG1_SPLIT = 6;
  localparam int CFG3_UNI   = 3;
  localparam int ST_CRC_OK  = 1;
  localparam int ST_CRC_REF = 2;
  // ==========================================
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG3_RST = 8'h08;
  // ==========================================
  // Command codes written to the command register
  localparam logic [7:0] CMD_ENTER4 = 8'h01;
  localparam logic [7:0] CMD_EXIT4  = 8'h02;
  localparam logic [7:0] CMD_CRCRD  = 8'h03;
  // ==========================================
  // Protocol modes, sector sizes, geometry
  localparam logic [1:0] PROTO_SPI = 2'h0;
  localparam logic [1:0] PROTO_8S  = 2'h1;
  localparam logic [1:0] PROTO_8D  = 2'h2;
  localparam logic [1:0] SZ_4K     = 2'h0;
  localparam logic [1:0] SZ_128K   = 2'h1;
  localparam logic [1:0] SZ_192K   = 2'h2;
  localparam logic [1:0] SZ_256K   = 2'h3;
  localparam logic [9:0] NSEC_MIN  = 10'h080;
  localparam logic [17:0] OFS_128K = 18'h20000;
  localparam logic [17:0] OFS_64K  = 18'h10000;
  localparam logic [17:0] OFS_192K = 18'h30000;
  localparam logic [9:0] NSMALL1  = 10'h020;
  localparam logic [9:0] NSMALL2  = 10'h010;
  typedef enum logic [1:0] {LAY_UNIFORM, LAY_BOTTOM, LAY_TOP, LAY_SPLIT}
    layout_t;
  typedef enum logic {PH_LOAD, PH_MID} phase_t;
endpackage

// ### rtl/word_buf2.sv
module word_buf2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // ==========================================
  // Storage: two entries, one-bit pointers
  logic [WIDTH-1:0] mem_r [2];   // Entry array
  logic             wp_r;        // Write pointer
  logic             rp_r;        // Read pointer
  logic [1:0]       cnt_r;       // Fill level
  logic             push;        // Accepted write
  logic             pop;         // Accepted read

  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers and level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      wp_r  <= wp_r ^ push;
      rp_r  <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Data entries, no reset needed
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  // Never more than two words held
  a_buf_level: assert property (@(posedge clk) disable iff (!nrst)
    cnt_r <= 2'h2) else $error("buffer level overflow");
endmodule

// ### dv/link_host.sv
module link_host (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Bench controls
  input  wire logic go,
  input  wire logic stall,
  // Link side of the device
  output logic      rd_phase,
  output logic      link_rdy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Frame and take control
  // host leaves strobe alone
  // No strobe driver exists here, so the pin is the device's alone
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_phase <= 1'b0;
      link_rdy <= 1'b0;
    end
    else
    begin
      rd_phase <= go;
      // Random stalls prove each word holds until taken
      link_rdy <= go & ~stall;
    end
  end
endmodule

// ### dv/oflash_map_strobe_tb.sv
module oflash_map_strobe_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Pins, scoreboard and counters
  logic        clk, nrst, rd, wr, wreq, go, stall, sdr, ds_p;
  logic        rd_phase, link_rdy, dq_oe_n, ds, ds_oe_n;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, rnd, srnd;
  logic [7:0]  dq, dq_p;
  logic [63:0] exp_rd[$];  // Mask and value of each read
  logic [7:0]  exp_dq[$];  // Bytes in push order
  int          n_fail, checked, cyc, waits;
  localparam logic [31:0] SM = 32'h00030fff;

  always #5 clk = ~clk;

  oflash_map_strobe dut (.CLK_SYS(clk), .NRST(nrst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .RD_PHASE(rd_phase),
    .LINK_RDY(link_rdy), .DQ_OUT(dq), .DQ_OE_N(dq_oe_n), .DS_OUT(ds),
    .DS_OE_N(ds_oe_n));
  link_host host (.clk(clk), .nrst(nrst), .go(go), .stall(stall),
    .rd_phase(rd_phase), .link_rdy(link_rdy));

  // ==========================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction

  function automatic logic [31:0] sect(input logic [1:0] l, s,
                                       input logic [9:0] i);
    return {14'h0, l, 4'h0, s, i};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    waits = 0;
    @(posedge clk);
    addr  <= a;
    wr    <= w;
    rd    <= ~w;
    wdata <= d;
    // No limit of its own: only the bench timeout ends a wait
    do
    begin
      @(posedge clk);
      waits++;
    end
    while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] m, e);
    exp_rd.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic lay(input logic [7:0] c, input logic [31:0] a,
                     input logic [1:0] l, s, input logic [9:0] i);
    bus(1'b1, oflash_pkg::OFS_CFG1, {24'h0, c});
    bus(1'b1, oflash_pkg::OFS_ADDR, a);
    rdc(oflash_pkg::OFS_SECT, SM, sect(l, s, i));
  endtask

  // Six bytes; the third is pushed into a full buffer
  task automatic stream(input logic s);
    int n;
    sdr = s;
    for (int k = 0; k < 6; k++)
    begin
      rnd = lfsr(rnd);
      exp_dq.push_back(rnd[7:0]);
      if (k == 2)
        fork
          begin
            repeat (20) @(posedge clk);
            go <= 1'b1;
          end
        join_none
      bus(1'b1, oflash_pkg::OFS_DATA, {24'h0, rnd[7:0]});
      if (k == 2)
        chk("full buffer wait", waits > 10, 1);
    end
    n = 0;
    while (exp_dq.size() > 0 && n < 300)
    begin
      n++;
      @(posedge clk);
    end
    chk("words left", exp_dq.size(), 0);
    chk("pins driven", {dq_oe_n, ds_oe_n}, 2'b00);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    chk("pins idle", {dq_oe_n, ds_oe_n, ds}, 3'b110);
    rdc(oflash_pkg::OFS_STAT, 32'h20, 32'h0);
    $display("test stream sdr=%0d finished", s);
  endtask

  // ==========================================
  // Watcher: timeout, stalls, read data, pin words
  always @(posedge clk)
  begin
    logic [63:0] e;
    cyc++;
    if (cyc > 20000)
    begin
      n_fail++;
      report_and_stop();
    end
    srnd = lfsr(srnd);
    stall <= srnd[0] & srnd[1];
    if (rd && !wreq && exp_rd.size() > 0)
    begin
      e = exp_rd.pop_front();
      chk("read data", rdata & e[63:32], e[31:0]);
    end
    // DDR: any strobe edge; SDR: rising strobe mid-word
    if (!ds_oe_n && ((!sdr && ds !== ds_p) || (sdr && ds && !ds_p)))
    begin
      if (sdr)
        chk("dq centred", dq, dq_p);
      chk("dq word", dq, exp_dq.size() > 0 ? exp_dq.pop_front() : 'x);
    end
    ds_p = ds;
    dq_p = dq;
  end

  // ==========================================
  // Main sequence
  initial
  begin
    clk = 0; nrst = 0; addr = 0; rd = 0; wr = 0; wdata = 0;
    go = 0; stall = 0; sdr = 0; ds_p = 0; dq_p = 0;
    n_fail = 0; checked = 0; cyc = 0; waits = 0;
    rnd = 32'he23dd0b3;
    srnd = 32'he23dd0b3;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    // Unmapped hole and reset values
    rdc(5'h02, 32'hffffffff, 32'h0);
    rdc(oflash_pkg::OFS_CTRL, 32'h1f, 32'h0);
    rdc(oflash_pkg::OFS_CFG1, 32'h44, 32'h0);
    rdc(oflash_pkg::OFS_CFG3, 32'h08, 32'h08);
    // Uniform map, 3-byte mode keeps 24 bits
    repeat (4)
    begin
      rnd = lfsr(rnd);
      bus(1'b1, oflash_pkg::OFS_ADDR, rnd);
      rdc(oflash_pkg::OFS_SECT, SM, sect(0, 3, rnd[23:18]));
    end
    $display("test uniform finished");
    // Mode by command and by register bit
    bus(1'b1, oflash_pkg::OFS_CMD, {24'h0, oflash_pkg::CMD_ENTER4});
    rdc(oflash_pkg::OFS_STAT, 32'h1, 32'h1);
    bus(1'b1, oflash_pkg::OFS_ADDR, 32'h01fc0000);
    rdc(oflash_pkg::OFS_SECT, SM, sect(0, 3, 127));
    bus(1'b1, oflash_pkg::OFS_CTRL, 32'h09);
    bus(1'b1, oflash_pkg::OFS_ADDR, 32'h03fc0000);
    rdc(oflash_pkg::OFS_SECT, SM, sect(0, 3, 255));
    bus(1'b1, oflash_pkg::OFS_CTRL, 32'h11);
    bus(1'b1, oflash_pkg::OFS_ADDR, 32'h07fc0000);
    rdc(oflash_pkg::OFS_SECT, SM, sect(0, 3, 511));
    bus(1'b1, oflash_pkg::OFS_CMD, {24'h0, oflash_pkg::CMD_EXIT4});
    rdc(oflash_pkg::OFS_STAT, 32'h11, 32'h0);
    bus(1'b1, oflash_pkg::OFS_CTRL, 32'h01);
    rdc(oflash_pkg::OFS_STAT, 32'h11, 32'h11);
    $display("test address mode finished");
    // Hybrid layouts on the smallest density, then uniform overriding a hybrid request
    bus(1'b1, oflash_pkg::OFS_CFG3, 32'h0);
    lay(8'h00, 32'h0001f000, 1, 0, 31);
    lay(8'h00, 32'h00020000, 1, 1, 32);
    lay(8'h00, 32'h00040000, 1, 3, 33);
    lay(8'h04, 32'h00000000, 2, 3, 0);
    lay(8'h04, 32'h01fc0000, 2, 1, 127);
    lay(8'h04, 32'h01fe0000, 2, 0, 128);
    lay(8'h40, 32'h0000f000, 3, 0, 15);
    lay(8'h40, 32'h00010000, 3, 2, 16);
    lay(8'h40, 32'h00040000, 3, 3, 17);
    bus(1'b1, oflash_pkg::OFS_CFG3, 32'h08);
    lay(8'h44, 32'h0001f000, 0, 3, 0);
    $display("test layouts finished");
    // CRC read only accepted in octal DDR
    for (int p = 0; p < 3; p++)
    begin
      bus(1'b1, oflash_pkg::OFS_STAT, 32'h6);
      bus(1'b1, oflash_pkg::OFS_CTRL, 32'(p * 2 + 1));
      bus(1'b1, oflash_pkg::OFS_CMD, {24'h0, oflash_pkg::CMD_CRCRD});
      rdc(oflash_pkg::OFS_STAT, 32'h6, p == 2 ? 32'h2 : 32'h4);
    end
    // Odd address flagged in octal DDR
    bus(1'b1, oflash_pkg::OFS_ADDR, 32'h00000101);
    rdc(oflash_pkg::OFS_STAT, 32'h8, 32'h8);
    bus(1'b1, oflash_pkg::OFS_ADDR, 32'h00000100);
    rdc(oflash_pkg::OFS_STAT, 32'h8, 32'h0);
    $display("test crc and address checks finished");
    // Read data streams, DDR then SDR
    stream(1'b0);
    bus(1'b1, oflash_pkg::OFS_CTRL, 32'h03);
    stream(1'b1);
    repeat (5) @(posedge clk);
    report_and_stop();
  end
endmodule
